// File: bench/dmt_props.sv
// Port-level checker for the data memory transfer unit
`timescale 1ns/1ps
`default_nettype none
module dmt_props import dmt_pkg::*; (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              srst,
  // Avalon-MM slave
  input wire logic [BUS_AW-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [BUS_DW-1:0] avs_writedata,
  input wire logic [BUS_DW-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  // Program memory table port
  input wire logic [INSN_W-1:0] romAddr,
  input wire logic              romRead,
  input wire logic [INSN_W-1:0] romData,
  input wire logic              romValid
);
  // ==========================================================================
  // Helper logic
  logic [15:0] tblAddr_q;
  wire         insnCommit = avs_write && !avs_waitrequest && (avs_address == REG_INSN);
  wire         tblCommit  = avs_write && !avs_waitrequest && (avs_address == REG_TBLADDR);

  // Shadow of the table address, so the fetch address can be judged
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tblAddr_q <= 16'h0000;
    end else if (tblCommit) begin
      tblAddr_q <= avs_writedata[15:0];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // ==========================================================================
  // Properties
  property p_rst_quiet;
    disable iff (1'b0) srst |=> avs_waitrequest && !romRead && (avs_readdata == 32'h0000_0000);
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");

  property p_ack_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("waitrequest low for more than one cycle");

  property p_ack_req;
    !avs_waitrequest |-> (avs_read || avs_write);
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("bus answered with no request");

  property p_rom_hold;
    romRead && !romValid |=> romRead && $stable(romAddr);
  endproperty
  a_rom_hold: assert property (p_rom_hold) else $error("table fetch dropped before data");

  property p_rom_drop;
    romRead && romValid |=> !romRead;
  endproperty
  a_rom_drop: assert property (p_rom_drop) else $error("table fetch held after data");

  property p_rom_addr;
    romRead |-> (romAddr == tblAddr_q);
  endproperty
  a_rom_addr: assert property (p_rom_addr) else $error("table fetch address wrong");

  property p_rom_busy;
    romRead |-> avs_waitrequest;
  endproperty
  a_rom_busy: assert property (p_rom_busy) else $error("bus served during table fetch");

  property p_tbl_start;
    insnCommit && (avs_writedata[15:0] == INSN_TBL_READ) |-> ##2 !romRead ##1 romRead;
  endproperty
  a_tbl_start: assert property (p_tbl_start) else $error("table fetch start late or early");

  property p_imm_busy;
    insnCommit && (avs_writedata[15:11] == OP_MOV_IMM) |=> avs_waitrequest [*3];
  endproperty
  a_imm_busy: assert property (p_imm_busy) else $error("bus served during execution");

  // Main scenarios reached
  c_tbl: cover property (insnCommit ##3 romRead);
  c_rom: cover property (romRead && romValid);
  c_rd:  cover property (avs_read && !avs_waitrequest);
endmodule

bind dmt_top dmt_props dmt_props_u (
  .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .romAddr(romAddr), .romRead(romRead),
  .romData(romData), .romValid(romValid)
);
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the data memory transfer unit
`timescale 1ns/1ps
`default_nettype none
module tb import dmt_pkg::*;;
  // ==========================================================================
  // Signals
  logic              clk_sys         = 1'b0;
  logic              srst            = 1'b1;
  logic [BUS_AW-1:0] avs_address     = 4'h0;
  logic              avs_read        = 1'b0;
  logic              avs_write       = 1'b0;
  logic [BUS_DW-1:0] avs_writedata   = 32'h0000_0000;
  logic [BUS_DW-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic [INSN_W-1:0] romAddr;
  logic              romRead;
  logic [INSN_W-1:0] romData         = 16'h0000;
  logic              romValid        = 1'b0;
  logic [31:0]       q;
  int                miscompares     = 0;
  int                comparisons     = 0;

  // 10 MHz clock
  always #50 clk_sys = ~clk_sys;

  dmt_top dut_u (
    .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .romAddr(romAddr), .romRead(romRead),
    .romData(romData), .romValid(romValid)
  );

  // ==========================================================================
  // Shared tasks
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus transfer; an edge first, so a release never meets a new request
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !w;
    avs_write     <= w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 400);
    q = avs_readdata;
    if (n >= 400) miscompares++;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask

  task automatic mem_set(input logic [10:0] addr, input logic [3:0] v);
    bus(1'b1, REG_MEMADDR, {21'h00_0000, addr});
    bus(1'b1, REG_MEMDATA, {28'h000_0000, v});
  endtask

  task automatic mem_chk(input logic [10:0] addr, input logic [3:0] exp);
    bus(1'b1, REG_MEMADDR, {21'h00_0000, addr});
    rd_chk(REG_MEMDATA, {28'h000_0000, exp});
  endtask

  task automatic exec(input logic [15:0] insn);
    bus(1'b1, REG_INSN, {16'h0000, insn});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_store;
    mem_set(11'h093, 4'h6);
    bus(1'b1, REG_REGPTR, 32'h0000_0012);
    exec({OP_STORE, 3'h2, 4'hF, 4'h3});
    mem_chk(11'h02F, 4'h6);
    bus(1'b1, REG_REGPTR, 32'h0000_0000);
    $display("test store done");
  endtask

  task automatic t_index_imm;
    exec({OP_MOV_IMM, 3'h5, 4'h0, 4'hA});
    mem_chk(11'h050, 4'hA);
    bus(1'b1, REG_INDEX, 32'h0000_0110);
    bus(1'b1, REG_FLAGS, 32'h0000_0001);
    exec({OP_MOV_IMM, 3'h2, 4'hF, 4'h7});
    bus(1'b1, REG_FLAGS, 32'h0000_0000);
    mem_chk(11'h13F, 4'h7);
    mem_chk(11'h02F, 4'h6);
    $display("test index immediate done");
  endtask

  // Both pointer settings, destination column from the register row
  task automatic t_ind_dst;
    for (int pe = 0; pe < 2; pe++) begin
      mem_set(11'h000, 4'hF);
      mem_set(11'h020, (pe == 1) ? 4'h5 : 4'hC);
      bus(1'b1, REG_MEMPTR, 32'h0000_0009);
      bus(1'b1, REG_FLAGS, (pe == 1) ? 32'h0000_0002 : 32'h0000_0000);
      exec({OP_MOV_IND_DST, 3'h2, 4'h0, 4'h0});
      mem_chk((pe == 1) ? 11'h09F : 11'h02F, (pe == 1) ? 4'h5 : 4'hC);
    end
    bus(1'b1, REG_FLAGS, 32'h0000_0000);
    $display("test indirect destination done");
  endtask

  task automatic t_ind_src;
    mem_set(11'h02F, 4'h3);
    mem_set(11'h09F, 4'hE);
    for (int pe = 0; pe < 2; pe++) begin
      bus(1'b1, REG_FLAGS, (pe == 1) ? 32'h0000_0002 : 32'h0000_0000);
      exec({OP_MOV_IND_SRC, 3'h2, 4'h0, 4'h0});
      mem_chk(11'h020, (pe == 1) ? 4'hE : 4'h3);
    end
    bus(1'b1, REG_FLAGS, 32'h0000_0000);
    $display("test indirect source done");
  endtask

  // Table fetch with a slow program memory, then the buffer seen from bank 0
  task automatic t_table;
    int n;
    bus(1'b1, REG_TBLADDR, 32'h0000_0011);
    bus(1'b1, REG_PC, 32'h0000_1234);
    bus(1'b1, REG_SP, 32'h0000_0003);
    rd_chk(REG_TBLADDR, 32'h0000_0011);
    exec(INSN_TBL_READ);
    n = 0;
    while (romRead !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    chk({16'h0000, romAddr}, 32'h0000_0011);
    chk({31'h00000000, romRead}, 32'h0000_0001);
    repeat (3) @(posedge clk_sys);
    romValid <= 1'b1;
    romData  <= 16'hABCD;
    @(posedge clk_sys);
    romValid <= 1'b0;
    romData  <= 16'h5432;
    rd_chk(REG_DATABUF, 32'h0000_ABCD);
    chk({31'h00000000, romRead}, 32'h0000_0000);
    rd_chk(REG_SP, 32'h0000_0003);
    rd_chk(REG_PC, 32'h0000_1234);
    bus(1'b1, REG_BANK, 32'h0000_0005);
    exec({OP_MOV_IMM, 3'h0, 4'hC, 4'h9});
    rd_chk(REG_DATABUF, 32'h0000_ABC9);
    mem_chk(11'h00F, 4'hA);
    bus(1'b1, REG_BANK, 32'h0000_0000);
    $display("test table read done");
  endtask

  // Mid-run reset clears the software-visible registers
  task automatic t_reset;
    bus(1'b1, REG_BANK, 32'h0000_0005);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    chk({31'h00000000, avs_waitrequest}, 32'h0000_0001);
    rd_chk(REG_BANK, 32'h0000_0000);
    rd_chk(REG_PC, 32'h0000_0000);
    $display("test reset done");
  endtask

  // Unmapped words read zero and ignore writes; unknown opcodes only flag
  task automatic t_unmapped;
    exec(16'h4000);
    rd_chk(REG_FLAGS, 32'h0000_0100);
    rd_chk(REG_INSN, 32'h0000_4000);
    bus(1'b1, REG_FLAGS, 32'h0000_0100);
    rd_chk(REG_FLAGS, 32'h0000_0000);
    bus(1'b1, 4'hE, 32'hFFFF_FFFF);
    rd_chk(4'hE, 32'h0000_0000);
    rd_chk(4'hF, 32'h0000_0000);
    $display("test unmapped done");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    t_store();
    t_index_imm();
    t_ind_dst();
    t_ind_src();
    t_table();
    t_reset();
    t_unmapped();
    print_verdict();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire

// File: src/dmt_data_mem.sv
// Data memory of 4-bit words with registered read data
`timescale 1ns/1ps
`default_nettype none
module dmt_data_mem import dmt_pkg::*; (
  // Clock
  input wire logic clk_sys,
  // Memory port
  dmt_mem_if.mem   port
);

  logic [NIB_W-1:0] mem_q [DMEM_DEPTH];
  logic [NIB_W-1:0] rdata_q;

  // ==========================================================================
  // Storage; a read in the write cycle returns the old word
  always_ff @(posedge clk_sys) begin
    if (port.we) begin
      mem_q[port.addr] <= port.wdata;
    end
    rdata_q <= mem_q[port.addr];
  end

  assign port.rdata = rdata_q;

endmodule
`default_nettype wire

// File: src/dmt_mem_if.sv
// Nibble memory port between sequencer and data memory
`timescale 1ns/1ps
`default_nettype none
interface dmt_mem_if import dmt_pkg::*; ;
  logic [ADDR_W-1:0] addr;
  logic              we;
  logic [NIB_W-1:0]  wdata;
  logic [NIB_W-1:0]  rdata;

  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// File: src/dmt_pkg.sv
// Shared constants and types for the data memory transfer unit
package dmt_pkg;

  // ==========================================================================
  // Widths and depths
  localparam int unsigned ADDR_W      = 11;
  localparam int unsigned NIB_W       = 4;
  localparam int unsigned INSN_W      = 16;
  localparam int unsigned SP_W        = 3;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned DMEM_DEPTH  = 2048;
  localparam int unsigned BUS_AW      = 4;
  localparam int unsigned BUS_DW      = 32;

  // ==========================================================================
  // Instruction fields and encodings
  localparam int unsigned OPC_LSB = 11;
  localparam int unsigned ROW_LSB = 8;
  localparam int unsigned COL_LSB = 4;
  localparam int unsigned ARG_LSB = 0;

  localparam logic [4:0]  OP_STORE       = 5'h18;
  localparam logic [4:0]  OP_MOV_IND_DST = 5'h0A;
  localparam logic [4:0]  OP_MOV_IND_SRC = 5'h1A;
  localparam logic [4:0]  OP_MOV_IMM     = 5'h1D;
  localparam logic [15:0] INSN_TBL_READ  = 16'h3810;

  // ==========================================================================
  // Data buffer placement in bank 0
  localparam logic [3:0] DBUF_BANK    = 4'h0;
  localparam logic [6:0] DBUF_ROW_COL = 7'h0C;

  // ==========================================================================
  // Register word offsets
  localparam logic [BUS_AW-1:0] REG_INSN    = 4'h0;
  localparam logic [BUS_AW-1:0] REG_FLAGS   = 4'h1;
  localparam logic [BUS_AW-1:0] REG_REGPTR  = 4'h2;
  localparam logic [BUS_AW-1:0] REG_MEMPTR  = 4'h3;
  localparam logic [BUS_AW-1:0] REG_INDEX   = 4'h4;
  localparam logic [BUS_AW-1:0] REG_BANK    = 4'h5;
  localparam logic [BUS_AW-1:0] REG_TBLADDR = 4'h6;
  localparam logic [BUS_AW-1:0] REG_DATABUF = 4'h7;
  localparam logic [BUS_AW-1:0] REG_PC      = 4'h8;
  localparam logic [BUS_AW-1:0] REG_SP      = 4'h9;
  localparam logic [BUS_AW-1:0] REG_MEMADDR = 4'hA;
  localparam logic [BUS_AW-1:0] REG_MEMDATA = 4'hB;

  // Flag register bit positions
  localparam int unsigned FLG_IDX_BIT     = 0;
  localparam int unsigned FLG_PTR_BIT     = 1;
  localparam int unsigned FLG_ILLEGAL_BIT = 8;

  // ==========================================================================
  // Reset values
  localparam logic [15:0]     PC_RST   = 16'h0000;
  localparam logic [SP_W-1:0] SP_RST   = 3'h0;
  localparam logic [3:0]      NIB_RST  = 4'h0;
  localparam logic [15:0]     WORD_RST = 16'h0000;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_DEC, S_GPR, S_SRC, S_WR, S_PUSH, S_ROM, S_POP, S_BRD, S_BACK, S_BWR
  } dmt_state_t;

endpackage

// File: src/dmt_top.sv
// Data transfer execution unit with Avalon-MM register access
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Store copies the selected general register into the memory operand location.
// - Indirect-destination move writes the memory operand to a column taken from a general register, row from the memory pointer when enabled.
// - With the pointer disabled the indirect-destination row and bank come from the operand's own upper address.
// - Indirect-source move reads a column given by a general register and writes it to the memory operand.
// - Indirect-source move takes bank and row from the operand itself, or from the memory pointer when enabled.
// - Immediate move writes the 4-bit immediate field to the memory operand location.
// - Table read fetches the program word at the table address and loads it into the data buffer.
// - Table read pushes the program counter, then pops it back, borrowing one stack level.
// - With indexing enabled the operand address is the OR of the index register and the bank-0 operand address.
// - The index register is 11 bits from high, mid and low parts, top four bits bank, low seven in-bank address.
// - A general-register operand uses only its low four bits as column within the register row.
// - The register row sits at the bank from the pointer high part and the row from the upper bits of the low part.
// - The memory pointer gives a bank in its upper bits and a 3-bit row in its lowest bits.
// - The data buffer is 16 bits in four nibbles, all filled by the table read.
// - The data buffer nibbles sit at fixed bank-0 locations whatever the bank register says.
module dmt_top import dmt_pkg::*; (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // Avalon-MM slave
  input  wire logic [BUS_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [BUS_DW-1:0] avs_writedata,
  output logic      [BUS_DW-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  // Program memory table port
  output logic      [INSN_W-1:0] romAddr,
  output logic                   romRead,
  input  wire logic [INSN_W-1:0] romData,
  input  wire logic              romValid
);

  // ==========================================================================
  // Helper functions
  // True when an address falls on the data buffer nibbles
  function automatic logic isDataBuf(input logic [ADDR_W-1:0] a);
    return (a[10:7] == DBUF_BANK) && (a[6:2] == DBUF_ROW_COL[6:2]);
  endfunction
  // Effective address of a memory operand
  function automatic logic [ADDR_W-1:0] effAddr(input logic [6:0] m, input logic idxOn,
                                                input logic [ADDR_W-1:0] idx, input logic [3:0] bank);
    if (idxOn) begin
      return {4'h0, m} | idx;
    end else if (m[6:2] == DBUF_ROW_COL[6:2]) begin
      return {DBUF_BANK, m};
    end else begin
      return {bank, m};
    end
  endfunction

  // ==========================================================================
  // State
  dmt_state_t        state_q;
  logic [INSN_W-1:0] insn_q;
  logic              idxEnable_q;
  logic              ptrEnable_q;
  logic              illegal_q;
  logic [3:0]        regPtrHigh_q;
  logic [3:0]        regPtrLow_q;
  logic [2:0]        memPtrHigh_q;
  logic [3:0]        memPtrLow_q;
  logic [2:0]        idxHigh_q;
  logic [3:0]        idxMid_q;
  logic [3:0]        idxLow_q;
  logic [3:0]        bank_q;
  logic [15:0]       tblAddr_q;
  logic [15:0]       dataBuf_q;
  logic [15:0]       pc_q;
  logic [SP_W-1:0]   sp_q;
  logic [15:0]       stack_q [STACK_DEPTH];
  logic [ADDR_W-1:0] winAddr_q;
  logic [ADDR_W-1:0] dstAddr_q;
  logic [ADDR_W-1:0] prevAddr_q;
  logic [NIB_W-1:0]  wrData_q;
  logic [BUS_DW-1:0] rdData_q;
  logic              wait_q;
  logic [15:0]       romAddr_q;
  logic              romRead_q;
  dmt_mem_if memBus ();
  dmt_data_mem uMem (
    .clk_sys (clk_sys),
    .port    (memBus.mem)
  );

  // ==========================================================================
  // Instruction field split
  wire [4:0]        opc    = insn_q[OPC_LSB +: 5];
  wire [2:0]        mRow   = insn_q[ROW_LSB +: 3];
  wire [3:0]        mCol   = insn_q[COL_LSB +: 4];
  wire [3:0]        arg    = insn_q[ARG_LSB +: 4];
  wire [ADDR_W-1:0] idxVal = {idxHigh_q, idxMid_q, idxLow_q};
  wire [6:0]        memPtr = {memPtrHigh_q, memPtrLow_q};

  // Operand addresses
  wire [ADDR_W-1:0] effM    = effAddr({mRow, mCol}, idxEnable_q, idxVal, bank_q);
  wire [2:0]        regPtrLowRow = regPtrLow_q[3:1];
  wire [ADDR_W-1:0] gprAddr = {regPtrHigh_q, regPtrLowRow, arg};
  wire [6:0]        rowSel  = ptrEnable_q ? memPtr : effM[10:4];

  // Read data, with the buffer nibbles taking the place of memory
  wire [NIB_W-1:0]  bufNib = dataBuf_q[{prevAddr_q[1:0], 2'b00} +: 4];
  wire [NIB_W-1:0]  rdVal  = isDataBuf(prevAddr_q) ? bufNib : memBus.rdata;

  // ==========================================================================
  // Memory address and write selection
  wire isIndDst = (opc == OP_MOV_IND_DST);
  wire busMemWr = (state_q == S_BWR) && avs_write && (avs_address == REG_MEMDATA);
  wire [ADDR_W-1:0] gprStep = isIndDst ? effM : {rowSel, rdVal};
  wire [ADDR_W-1:0] curAddr =
    (state_q == S_DEC) ? gprAddr :
    (state_q == S_GPR) ? gprStep :
    (state_q == S_WR)  ? dstAddr_q : winAddr_q;
  wire              logWe   = (state_q == S_WR) || busMemWr;
  wire [NIB_W-1:0]  logData = (state_q == S_WR) ? wrData_q : avs_writedata[3:0];
  wire              bufWe   = logWe && isDataBuf(curAddr);

  assign memBus.addr  = curAddr;
  assign memBus.we    = logWe && !isDataBuf(curAddr);
  assign memBus.wdata = logData;

  // ==========================================================================
  // Register read selection
  logic [BUS_DW-1:0] regRd;
  always_comb begin
    regRd = '0;
    case (avs_address)
      REG_INSN:    regRd = {16'h0000, insn_q};
      REG_FLAGS: begin
        regRd[FLG_IDX_BIT]     = idxEnable_q;
        regRd[FLG_PTR_BIT]     = ptrEnable_q;
        regRd[FLG_ILLEGAL_BIT] = illegal_q;
      end
      REG_REGPTR:  regRd = {24'h000000, regPtrHigh_q, regPtrLow_q};
      REG_MEMPTR:  regRd = {25'h0000000, memPtr};
      REG_INDEX:   regRd = {21'h000000, idxVal};
      REG_BANK:    regRd = {28'h0000000, bank_q};
      REG_TBLADDR: regRd = {16'h0000, tblAddr_q};
      REG_DATABUF: regRd = {16'h0000, dataBuf_q};
      REG_PC:      regRd = {16'h0000, pc_q};
      REG_SP:      regRd = {29'h00000000, sp_q};
      REG_MEMADDR: regRd = {21'h000000, winAddr_q};
      REG_MEMDATA: regRd = {28'h0000000, rdVal};
      default:     regRd = '0;
    endcase
  end

  // ==========================================================================
  // Sequencer; one instruction runs to the end before the bus is served again,
  // so software sees waitrequest stretch rather than a half-done transfer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q   <= S_IDLE;
      wait_q    <= 1'b1;
      rdData_q  <= '0;
      insn_q    <= WORD_RST;
      dstAddr_q <= '0;
      wrData_q  <= NIB_RST;
      romAddr_q <= WORD_RST;
      romRead_q <= 1'b0;
      illegal_q <= 1'b0;
      pc_q      <= PC_RST;
      sp_q      <= SP_RST;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (avs_read && wait_q) begin
            state_q <= S_BRD;
          end else if (avs_write && wait_q) begin
            wait_q  <= 1'b0;
            state_q <= S_BWR;
          end
        end
        S_BRD: begin
          rdData_q <= regRd;
          wait_q   <= 1'b0;
          state_q  <= S_BACK;
        end
        S_BACK: begin
          wait_q  <= 1'b1;
          state_q <= S_IDLE;
        end
        S_BWR: begin
          wait_q  <= 1'b1;
          state_q <= S_IDLE;
          case (avs_address)
            REG_INSN: begin
              insn_q  <= avs_writedata[15:0];
              state_q <= S_DEC;
            end
            REG_FLAGS: illegal_q <= avs_writedata[FLG_ILLEGAL_BIT] ? 1'b0 : illegal_q;
            REG_PC:  pc_q <= avs_writedata[15:0];
            REG_SP:  sp_q <= avs_writedata[SP_W-1:0];
            default: ;
          endcase
        end
        S_DEC: begin
          state_q <= S_IDLE;
          if (insn_q == INSN_TBL_READ) begin
            state_q <= S_PUSH;
          end else if (opc == OP_MOV_IMM) begin
            dstAddr_q <= effM;
            wrData_q  <= arg;
            state_q   <= S_WR;
          end else if (opc == OP_STORE || opc == OP_MOV_IND_DST || opc == OP_MOV_IND_SRC) begin
            state_q <= S_GPR;
          end else begin
            illegal_q <= 1'b1;
          end
        end
        S_GPR: begin
          if (opc == OP_STORE) begin
            dstAddr_q <= effM;
            wrData_q  <= rdVal;
            state_q   <= S_WR;
          end else if (isIndDst) begin
            dstAddr_q <= {rowSel, rdVal};
            state_q   <= S_SRC;
          end else begin
            dstAddr_q <= effM;
            state_q   <= S_SRC;
          end
        end
        S_SRC: begin
          wrData_q <= rdVal;
          state_q  <= S_WR;
        end
        S_WR:    state_q <= S_IDLE;
        S_PUSH: begin
          sp_q      <= sp_q - 3'h1;
          romAddr_q <= tblAddr_q;
          romRead_q <= 1'b1;
          state_q   <= S_ROM;
        end
        S_ROM: begin
          if (romValid) begin
            romRead_q <= 1'b0;
            state_q   <= S_POP;
          end
        end
        S_POP: begin
          pc_q    <= stack_q[sp_q];
          sp_q    <= sp_q + 3'h1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Stack storage; contents need no reset, only the pointer does
  always_ff @(posedge clk_sys) begin
    if (state_q == S_PUSH) begin
      stack_q[sp_q - 3'h1] <= pc_q;
    end
  end

  // ==========================================================================
  // Data buffer: bus, nibble writes and the table fetch share it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dataBuf_q <= WORD_RST;
    end else if (state_q == S_ROM && romValid) begin
      dataBuf_q <= romData;
    end else if (bufWe) begin
      dataBuf_q[{curAddr[1:0], 2'b00} +: 4] <= logData;
    end else if (state_q == S_BWR && avs_write && avs_address == REG_DATABUF) begin
      dataBuf_q <= avs_writedata[15:0];
    end
  end

  // ==========================================================================
  // Pointer, index and configuration registers written by software
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      idxEnable_q  <= 1'b0;
      ptrEnable_q  <= 1'b0;
      regPtrHigh_q <= NIB_RST;
      regPtrLow_q  <= NIB_RST;
      memPtrHigh_q <= 3'h0;
      memPtrLow_q  <= NIB_RST;
      idxHigh_q    <= 3'h0;
      idxMid_q     <= NIB_RST;
      idxLow_q     <= NIB_RST;
      bank_q       <= NIB_RST;
      tblAddr_q    <= WORD_RST;
      winAddr_q    <= '0;
    end else if (state_q == S_BWR && avs_write) begin
      case (avs_address)
        REG_FLAGS: begin
          idxEnable_q <= avs_writedata[FLG_IDX_BIT];
          ptrEnable_q <= avs_writedata[FLG_PTR_BIT];
        end
        REG_REGPTR: begin
          regPtrHigh_q <= avs_writedata[7:4];
          regPtrLow_q  <= avs_writedata[3:0];
        end
        REG_MEMPTR: begin
          memPtrHigh_q <= avs_writedata[6:4];
          memPtrLow_q  <= avs_writedata[3:0];
        end
        REG_INDEX: begin
          idxHigh_q <= avs_writedata[10:8];
          idxMid_q  <= avs_writedata[7:4];
          idxLow_q  <= avs_writedata[3:0];
        end
        REG_BANK:    bank_q    <= avs_writedata[3:0];
        REG_TBLADDR: tblAddr_q <= avs_writedata[15:0];
        REG_MEMADDR: winAddr_q <= avs_writedata[ADDR_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Last presented address, so read data can be steered to the buffer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prevAddr_q <= '0;
    end else begin
      prevAddr_q <= curAddr;
    end
  end
  // Outputs straight from flip-flops
  assign avs_readdata    = rdData_q;
  assign avs_waitrequest = wait_q;
  assign romAddr         = romAddr_q;
  assign romRead         = romRead_q;

endmodule
`default_nettype wire
